// ### hdl/ocs_pkg.sv
// Purpose: Shared constants and types of the output clock sync and test pattern block
// Assumes: 40 MHz core clock; sample clock is sampled as a slow input
// Notes:   Offsets are byte addresses on the plain register port

package ocs_pkg;

  // ****************************************************
  // Register port and map
  // ****************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PHASE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DELAY = 4'hC;

  // Control register fields
  localparam int CTRL_PATTERN_BIT = 0;
  localparam int CTRL_DEMUX_BIT = 1;
  localparam int CTRL_DDR_BIT = 2;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_CONT_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h02;

  // Phase register fields
  localparam int INTER_LSB = 7;
  localparam int INTER_MSB = 9;
  localparam int COARSE_LSB = 10;
  localparam int COARSE_MSB = 14;
  localparam int POL_BIT = 15;
  localparam logic [2:0] INTER_RST = 3'h0;
  localparam logic [4:0] COARSE_RST = 5'h00;

  // Status register fields
  localparam int ST_RUN_BIT = 0;
  localparam int ST_HELD_BIT = 1;
  localparam int ST_CAL_BIT = 2;
  localparam int ST_PAT_BIT = 3;

  // ****************************************************
  // Phase delay figures in picoseconds
  // ****************************************************
  localparam logic [11:0] INTER_STEP_PS = 12'h00B;
  localparam logic [11:0] COARSE_STEP_PS = 12'h041;
  localparam logic [11:0] MAX_DELAY_PS = 12'h834;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam logic [2:0] WAIT_DEMUX_DDR0 = 3'h4;
  localparam logic [2:0] WAIT_OTHER = 3'h3;
  localparam int CORE_PERIOD_PS = 25000;
  localparam int TOP_NS = 4;
  localparam int TOP_CYC_RAW = (TOP_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam logic [3:0] TOP_CYC = 4'(TOP_CYC_RAW < 1 ? 1 : TOP_CYC_RAW);
  localparam logic [1:0] HALVES_DEMUX = 2'h3;
  localparam logic [1:0] HALVES_NONDEMUX = 2'h1;

  // ****************************************************
  // Test pattern
  // ****************************************************
  localparam logic [7:0] PAT_QD = 8'h01;
  localparam logic [7:0] PAT_ID = 8'h02;
  localparam logic [7:0] PAT_Q = 8'h03;
  localparam logic [7:0] PAT_I = 8'h04;
  localparam logic [7:0] PAT_ND_Q = 8'h01;
  localparam logic [7:0] PAT_ND_I = 8'h02;
  localparam logic [3:0] PAT_LEN_DEMUX = 4'h5;
  localparam logic [3:0] PAT_LEN_NONDEMUX = 4'hA;
  localparam logic [9:0] PAT_SEQ_DEMUX = 10'h00A;
  localparam logic [9:0] PAT_SEQ_NONDEMUX = 10'h132;

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic [7:0] qd;
    logic [7:0] id;
    logic [7:0] q;
    logic [7:0] i;
    logic oor;
  } ocs_word_s;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD,
    ST_LATCH,
    ST_WAIT,
    ST_LAT
  } ocs_state_e;

endpackage

// ### hdl/ocs_pattern_gen.sv
// Purpose: Alternating test pattern word generator
// Assumes: i_step pulses once per output word slot
// Notes:   Index restarts at the first word while i_restart is high

`timescale 1ns/10ps

module ocs_pattern_gen (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_restart,
  input wire logic i_step,
  input wire logic i_demux,
  output ocs_pkg::ocs_word_s o_word
);

  logic [3:0] idx_q;
  logic [3:0] len;
  logic inv;

  // ****************************************************
  // Sequence index
  // ****************************************************
  assign len = i_demux ? ocs_pkg::PAT_LEN_DEMUX : ocs_pkg::PAT_LEN_NONDEMUX;

  // Step through the sequence once per word slot
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_restart) begin
      idx_q <= 4'h0;
    end else if (i_step) begin
      idx_q <= (idx_q == len - 4'h1) ? 4'h0 : idx_q + 4'h1;
    end
  end

  // ****************************************************
  // Word values
  // ****************************************************
  assign inv = i_demux ? ocs_pkg::PAT_SEQ_DEMUX[idx_q] : ocs_pkg::PAT_SEQ_NONDEMUX[idx_q];

  // Base word or its complement, out of range follows the complement
  always_comb begin
    if (i_demux) begin
      o_word.qd = ocs_pkg::PAT_QD ^ {8{inv}};
      o_word.id = ocs_pkg::PAT_ID ^ {8{inv}};
      o_word.q = ocs_pkg::PAT_Q ^ {8{inv}};
      o_word.i = ocs_pkg::PAT_I ^ {8{inv}};
    end else begin
      o_word.qd = 8'h00;
      o_word.id = 8'h00;
      o_word.q = ocs_pkg::PAT_ND_Q ^ {8{inv}};
      o_word.i = ocs_pkg::PAT_ND_I ^ {8{inv}};
    end
    o_word.oor = inv;
  end

endmodule

// ### hdl/ocs_top.sv
// Purpose: Output clock synchronisation and test pattern output of a dual converter
// Assumes: Sample clock, output clock reset and calibration flag come from outside
// Notes:   Sample clock edges are found by oversampling with the core clock
//
// Summary of operation
// - Intermediate phase field adds 11 ps steps
// - Total phase delay capped near 2.1 ns
// - Output clock reset accepted at any time
// - Output clock held at mode dependent level
// - Narrow output clock pulse possible at assertion
// - Reset release latched on next falling edge
// - Wait four or three cycles, then align
// - Restart output clock after fixed output latency
// - Output clock stops during calibration unless continuous
// - Pattern mode replaces converter data on all ports
// - Demux pattern words and their complements
// - Demux sequence repeats every five words
// - Non-demux sequence repeats every ten words
// - I and Q pairs may slip one period
// - Pattern starts when output clock restarts after reset
// - Pattern runs in all output modes

`timescale 1ns/10ps

module ocs_top (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_sample_clk,
  input wire logic i_output_clock_reset,
  input wire logic i_calibration_running,
  input wire ocs_pkg::ocs_word_s i_conv_word,
  input wire logic [ocs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ocs_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [ocs_pkg::DATA_W-1:0] o_rd_data,
  output logic o_data_output_clock,
  output ocs_pkg::ocs_word_s o_port_word
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [1:0] clk_sync_q;
  logic clk_prev_q;
  logic [1:0] rst_sync_q;
  logic [1:0] cal_sync_q;
  logic raw_rise;
  logic raw_fall;
  logic s_rise;
  logic s_fall;
  logic s_edge;
  logic [4:0] ctrl_q;
  logic [2:0] inter_q;
  logic [4:0] coarse_q;
  logic pol_q;
  logic [11:0] delay_ps;
  logic [11:0] delay_raw;
  logic [ocs_pkg::DATA_W-1:0] rd_q;
  logic [ocs_pkg::DATA_W-1:0] rd_d;
  ocs_pkg::ocs_state_e state_q;
  logic [2:0] wait_cnt_q;
  logic [2:0] wait_n;
  logic [3:0] lat_cnt_q;
  logic [1:0] half_q;
  logic [1:0] half_next;
  logic [1:0] halves_max;
  logic word_slot;
  logic ddr_lvl_q;
  logic rest_lvl;
  logic data_output_clock_d;
  logic data_output_clock_q;
  logic clk_hold;
  ocs_pkg::ocs_word_s pat_word;
  ocs_pkg::ocs_word_s word_q;
  logic pat_en;
  logic demux;
  logic ddr;
  logic edge_sel;
  logic cont;
  logic rst_sync;
  logic cal_sync;

  assign pat_en = ctrl_q[ocs_pkg::CTRL_PATTERN_BIT];
  assign demux = ctrl_q[ocs_pkg::CTRL_DEMUX_BIT];
  assign ddr = ctrl_q[ocs_pkg::CTRL_DDR_BIT];
  assign edge_sel = ctrl_q[ocs_pkg::CTRL_EDGE_BIT];
  assign cont = ctrl_q[ocs_pkg::CTRL_CONT_BIT];
  assign rst_sync = rst_sync_q[1];
  assign cal_sync = cal_sync_q[1];

  // ****************************************************
  // Input synchronisers
  // ****************************************************

  // Two stages for the sample clock, output clock reset and calibration flag; the reset may come at any phase
  // Only the second stage is read by any logic, so a metastable first stage
  // never reaches the edge finder or the sequence state.
  // The sampled sample clock lags the pin by one to two core cycles, which
  // shifts every derived edge by the same amount and keeps their spacing.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      clk_sync_q <= 2'h0;
      rst_sync_q <= 2'h0;
      cal_sync_q <= 2'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[0], i_sample_clk};
      rst_sync_q <= {rst_sync_q[0], i_output_clock_reset};
      cal_sync_q <= {cal_sync_q[0], i_calibration_running};
    end
  end

  // Previous sampled level for edge finding
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_sync_q[1];
    end
  end

  // Sample clock edges, swapped when the polarity bit inverts the clock
  assign raw_rise = clk_sync_q[1] & ~clk_prev_q;
  assign raw_fall = ~clk_sync_q[1] & clk_prev_q;
  assign s_rise = pol_q ? raw_fall : raw_rise;
  assign s_fall = pol_q ? raw_rise : raw_fall;
  assign s_edge = s_rise | s_fall;

  // ****************************************************
  // Registers
  // ****************************************************

  // Control and phase registers written by software
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= ocs_pkg::CTRL_RST;
      inter_q <= ocs_pkg::INTER_RST;
      coarse_q <= ocs_pkg::COARSE_RST;
      pol_q <= 1'b0;
    end else if (i_wr_en) begin
      if (i_addr == ocs_pkg::REG_CTRL) begin
        ctrl_q <= i_wr_data[4:0];
      end
      if (i_addr == ocs_pkg::REG_PHASE) begin
        inter_q <= i_wr_data[ocs_pkg::INTER_MSB:ocs_pkg::INTER_LSB];
        coarse_q <= i_wr_data[ocs_pkg::COARSE_MSB:ocs_pkg::COARSE_LSB];
        pol_q <= i_wr_data[ocs_pkg::POL_BIT];
      end
    end
  end

  // Total sample clock delay in picoseconds, limited to the maximum
  assign delay_raw = 12'(coarse_q * ocs_pkg::COARSE_STEP_PS) + 12'(inter_q * ocs_pkg::INTER_STEP_PS);
  assign delay_ps = (delay_raw > ocs_pkg::MAX_DELAY_PS) ? ocs_pkg::MAX_DELAY_PS : delay_raw;

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_d = '0;
    unique case (i_addr)
      ocs_pkg::REG_CTRL: begin
        rd_d[4:0] = ctrl_q;
      end
      ocs_pkg::REG_PHASE: begin
        rd_d[ocs_pkg::INTER_MSB:ocs_pkg::INTER_LSB] = inter_q;
        rd_d[ocs_pkg::COARSE_MSB:ocs_pkg::COARSE_LSB] = coarse_q;
        rd_d[ocs_pkg::POL_BIT] = pol_q;
      end
      ocs_pkg::REG_STATUS: begin
        rd_d[ocs_pkg::ST_RUN_BIT] = (state_q == ocs_pkg::ST_RUN);
        rd_d[ocs_pkg::ST_HELD_BIT] = (state_q == ocs_pkg::ST_HOLD);
        rd_d[ocs_pkg::ST_CAL_BIT] = cal_sync;
        rd_d[ocs_pkg::ST_PAT_BIT] = pat_en & (state_q == ocs_pkg::ST_RUN);
      end
      ocs_pkg::REG_DELAY: begin
        rd_d[11:0] = delay_ps;
      end
      default: begin
        rd_d = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_q <= '0;
    end else if (i_rd_en) begin
      rd_q <= rd_d;
    end else begin
      rd_q <= '0;
    end
  end

  // ****************************************************
  // Output clock synchronisation sequence
  // ****************************************************

  // Systematic wait, longer in demux double data rate zero degree mode
  assign wait_n = (demux && ddr && !edge_sel) ? ocs_pkg::WAIT_DEMUX_DDR0 : ocs_pkg::WAIT_OTHER;

  // Reset hold, release latch, wait, latency, run
  // HOLD lasts while the synchronised reset is high and holds the clock still.
  // LATCH waits for the first falling sample edge after release.
  // WAIT counts the systematic delay in falling sample edges.
  // LAT stands for the fixed output latency before the clock restarts.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= ocs_pkg::ST_RUN;
      wait_cnt_q <= 3'h0;
      lat_cnt_q <= 4'h0;
    end else if (rst_sync) begin
      state_q <= ocs_pkg::ST_HOLD;
      wait_cnt_q <= 3'h0;
      lat_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        ocs_pkg::ST_HOLD: begin
          state_q <= ocs_pkg::ST_LATCH;
        end
        ocs_pkg::ST_LATCH: begin
          if (s_fall) begin
            state_q <= ocs_pkg::ST_WAIT;
          end
        end
        ocs_pkg::ST_WAIT: begin
          if (s_fall) begin
            if (wait_cnt_q == wait_n - 3'h1) begin
              state_q <= ocs_pkg::ST_LAT;
              wait_cnt_q <= 3'h0;
            end else begin
              wait_cnt_q <= wait_cnt_q + 3'h1;
            end
          end
        end
        ocs_pkg::ST_LAT: begin
          if (lat_cnt_q == ocs_pkg::TOP_CYC - 4'h1) begin
            state_q <= ocs_pkg::ST_RUN;
            lat_cnt_q <= 4'h0;
          end else begin
            lat_cnt_q <= lat_cnt_q + 4'h1;
          end
        end
        ocs_pkg::ST_RUN: begin
          state_q <= ocs_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ****************************************************
  // Word timing
  // ****************************************************

  // Sample clock half periods per output word
  // The counter is parked on its last value while held, so the first edge
  // in RUN opens word zero and all ports start together.
  assign halves_max = demux ? ocs_pkg::HALVES_DEMUX : ocs_pkg::HALVES_NONDEMUX;
  assign half_next = (half_q == halves_max) ? 2'h0 : half_q + 2'h1;
  assign word_slot = (state_q == ocs_pkg::ST_RUN) && s_edge && (half_next == 2'h0);

  // Half period counter parked while held, zeroed at the first sample edge after the wait
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      half_q <= 2'h0;
    end else if (state_q == ocs_pkg::ST_HOLD || state_q == ocs_pkg::ST_LATCH || state_q == ocs_pkg::ST_WAIT) begin
      half_q <= halves_max;
    end else if (s_edge) begin
      half_q <= half_next;
    end
  end

  // ****************************************************
  // Data output clock
  // ****************************************************

  // Resting level: low in double rate, edge select level in single rate
  // Receivers must treat the clock as stopped while it rests.
  assign rest_lvl = ddr ? 1'b0 : edge_sel;
  assign clk_hold = (state_q != ocs_pkg::ST_RUN) || (cal_sync && !cont);

  // Double rate level toggles once per word, on the boundary or mid word
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || clk_hold) begin
      ddr_lvl_q <= 1'b0;
    end else if (s_edge && (half_next == (edge_sel ? {1'b0, halves_max[1]} + 2'h1 : 2'h0))) begin
      ddr_lvl_q <= ~ddr_lvl_q;
    end
  end

  // Single rate is high in the first half of each word, low there when edge select is set
  always_comb begin
    if (clk_hold) begin
      data_output_clock_d = rest_lvl;
    end else if (ddr) begin
      data_output_clock_d = ddr_lvl_q;
    end else begin
      data_output_clock_d = (half_q <= {1'b0, halves_max[1]}) ^ edge_sel;
    end
  end

  // Level follows the hold at once, so a short pulse may appear at assertion
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      data_output_clock_q <= 1'b0;
    end else begin
      data_output_clock_q <= data_output_clock_d;
    end
  end

  assign o_data_output_clock = data_output_clock_q;

  // ****************************************************
  // Data ports and test pattern
  // ****************************************************

  // Pattern index restarts while the sequence is not running
  // Holding the reset while enabling the pattern gives an aligned first word.
  ocs_pattern_gen u_pattern (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_restart(state_q != ocs_pkg::ST_RUN),
    .i_step(word_slot && pat_en),
    .i_demux(demux),
    .o_word(pat_word)
  );

  // One word per slot, pattern replaces converter data when enabled
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      word_q <= '0;
    end else if (word_slot) begin
      word_q <= pat_en ? pat_word : i_conv_word;
    end
  end

  assign o_port_word = word_q;
  assign o_rd_data = rd_q;

endmodule

// ### verification/ocs_top_props.sv
// Purpose: Checker on the ports of ocs_top
// Assumes: One core clock domain, synchronous reset
// Notes:   Control and phase bits are shadowed from register writes
`timescale 1ns/10ps
module ocs_top_props (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_sample_clk,
  input wire logic i_output_clock_reset,
  input wire logic i_calibration_running,
  input wire ocs_pkg::ocs_word_s i_conv_word,
  input wire logic [ocs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ocs_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [ocs_pkg::DATA_W-1:0] o_rd_data,
  input wire logic o_data_output_clock,
  input wire ocs_pkg::ocs_word_s o_port_word
);
  // ****************
  // Helper logic
  // ****************
  logic [4:0] ctrl_q;
  logic [15:0] phase_q;
  logic [7:0] quiet_q;
  logic [3:0] since_wr_q;
  logic [15:0] sum_w;
  logic [15:0] dly_w;
  // Shadow copies of control and phase
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= ocs_pkg::CTRL_RST;
      phase_q <= 16'h0000;
    end else if (i_wr_en && i_addr == ocs_pkg::REG_CTRL) begin
      ctrl_q <= i_wr_data[4:0];
    end else if (i_wr_en && i_addr == ocs_pkg::REG_PHASE) begin
      phase_q <= i_wr_data;
    end
  end
  // Cycles since the last hold or write, saturating
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_output_clock_reset || i_wr_en) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hFF) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  // Cycles since the last write, saturating
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_wr_en) begin
      since_wr_q <= 4'h0;
    end else if (since_wr_q != 4'hF) begin
      since_wr_q <= since_wr_q + 4'h1;
    end
  end
  // Expected delay readback in picoseconds
  assign sum_w = 16'(phase_q[14:10]) * 16'h0041 + 16'(phase_q[9:7]) * 16'h000B;
  assign dly_w = (sum_w > 16'h0834) ? 16'h0834 : sum_w;

  function automatic logic is_pat(input ocs_pkg::ocs_word_s w, input logic d);
    ocs_pkg::ocs_word_s b;
    b = d ? {8'h01, 8'h02, 8'h03, 8'h04, 1'b0} : {16'h0000, 8'h01, 8'h02, 1'b0};
    return (w == b) || (w == (d ? ~b : {16'h0000, 8'hFE, 8'hFD, 1'b1}));
  endfunction

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_fall;
    $fell(i_output_clock_reset) && $past(i_output_clock_reset, 8) && !i_calibration_running;
  endsequence
  sequence s_quiet;
    $stable(o_data_output_clock) [*8] ##1 $stable(o_data_output_clock) [*8];
  endsequence

  a_delay_value: assert property (
    i_rd_en && i_addr == ocs_pkg::REG_DELAY |=> o_rd_data == dly_w) else $error("delay readback wrong");
  a_delay_cap: assert property (
    i_rd_en && i_addr == ocs_pkg::REG_DELAY |=> o_rd_data <= 16'h0834) else $error("delay above cap");
  a_held_still: assert property (
    i_output_clock_reset [*6] ##0 since_wr_q > 4'h4 |-> $stable(o_data_output_clock))
    else $error("output clock moved while held");
  a_release_quiet: assert property (s_fall |-> s_quiet)
    else $error("output clock resumed too early");
  a_release_resume: assert property (
    s_fall |-> ##[17:100] $changed(o_data_output_clock)) else $error("output clock did not resume");
  a_cal_stop: assert property (
    (i_calibration_running && !ctrl_q[ocs_pkg::CTRL_CONT_BIT]) [*6] |-> $stable(o_data_output_clock))
    else $error("output clock ran during calibration");
  a_pattern_set: assert property (
    ctrl_q[ocs_pkg::CTRL_PATTERN_BIT] && quiet_q == 8'hFF |-> is_pat(o_port_word, ctrl_q[ocs_pkg::CTRL_DEMUX_BIT]))
    else $error("port word not a pattern word");
  a_word_slot: assert property (
    $changed(o_port_word) |=> $stable(o_port_word) [*6]) else $error("port word changed inside a slot");
endmodule

bind ocs_top ocs_top_props u_props (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sample_clk(i_sample_clk),
  .i_output_clock_reset(i_output_clock_reset), .i_calibration_running(i_calibration_running),
  .i_conv_word(i_conv_word), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .o_data_output_clock(o_data_output_clock), .o_port_word(o_port_word));

// ### verification/ocs_capture_model.sv
// Purpose: Far side model: shared sample clock and reset pulse source
// Assumes: Sample clock period 200 ns, free running
// Notes:   Pulse release lands just after a rising sample edge
`timescale 1ns/10ps
module ocs_capture_model (
  output logic o_sample_clk,
  output logic o_output_clock_reset
);
  // ****************
  // Sample clock, unrelated in phase to the core clock
  // ****************
  initial begin
    o_sample_clk = 1'b0;
    #7;
    forever #100 o_sample_clk = ~o_sample_clk;
  end
  initial o_output_clock_reset = 1'b0;
  // Assert at any phase, never while calibration runs
  task automatic pulse_on(input logic cal);
    if (!cal) #3 o_output_clock_reset = 1'b1;
  endtask
  // Release on a rising sample edge; caller keeps the pulse short
  task automatic pulse_off();
    @(posedge o_sample_clk);
    #1 o_output_clock_reset = 1'b0;
  endtask
endmodule

// ### verification/ocs_top_test.sv
// Purpose: Self-checking bench of ocs_top
// Assumes: 40 MHz core clock, 200 ns sample clock
// Notes:   Words are sampled two cycles after each word start
`timescale 1ns/10ps
module ocs_top_test;
  logic clk, rst, cal, wr, rd, data_output_clock, sclk, orst;
  logic [3:0] addr;
  logic [15:0] wd, rdd;
  int mismatches, comparisons, lat0, lat1, n;
  ocs_pkg::ocs_word_s conv, word;

  ocs_capture_model u_cap (.o_sample_clk(sclk), .o_output_clock_reset(orst));
  ocs_top u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_sample_clk(sclk), .i_output_clock_reset(orst),
    .i_calibration_running(cal), .i_conv_word(conv), .i_addr(addr), .i_wr_data(wd), .i_wr_en(wr),
    .i_rd_en(rd), .o_rd_data(rdd), .o_data_output_clock(data_output_clock), .o_port_word(word));

  // ****************
  // Shared tasks
  // ****************
  function automatic ocs_pkg::ocs_word_s exp_word(input logic dmx, input logic cmp);
    ocs_pkg::ocs_word_s w;
    w = dmx ? {8'h01, 8'h02, 8'h03, 8'h04, 1'b0} : {16'h0000, 8'h01, 8'h02, 1'b0};
    if (cmp) w = dmx ? ~w : {16'h0000, 8'hFE, 8'hFD, 1'b1};
    return w;
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, 33'(e), 33'(rdd));
  endtask
  // Waits while the output clock equals v, bounded
  task automatic wait_ne(input logic v);
    int j;
    j = 0;
    while (data_output_clock === v && j < 40) begin
      @(posedge clk);
      #1 j++;
    end
  endtask
  task automatic count_chg(output int c);
    logic p;
    c = 0;
    p = data_output_clock;
    repeat (32) begin
      @(posedge clk);
      #1 c += int'(data_output_clock !== p);
      p = data_output_clock;
    end
  endtask
  // Pattern start under a held reset, then two full sequences
  task automatic run_mode(input logic [15:0] c, input logic [9:0] seq, input int len, output int lat);
    logic rest;
    rest = c[2] ? 1'b0 : c[3];
    u_cap.pulse_on(cal);
    repeat (8) @(posedge clk);
    reg_wr(ocs_pkg::REG_CTRL, c);
    repeat (8) @(posedge clk);
    #1 chk("rest level", 33'(rest), 33'(data_output_clock));
    rchk(ocs_pkg::REG_STATUS, 16'h0002, "status held");
    u_cap.pulse_off();
    lat = 0;
    while (data_output_clock === rest && lat < 200) begin
      @(posedge clk);
      #1 lat++;
    end
    for (int k = 0; k < 2 * len; k++) begin
      repeat (2) @(posedge clk);
      #1 chk("port word", exp_word(c[1], seq[len - 1 - k % len]), word);
      if (c[2]) wait_ne(data_output_clock);
      else wait_ne(~rest);
      if (!c[2]) wait_ne(rest);
    end
    rchk(ocs_pkg::REG_STATUS, 16'h0009, "status run");
    $display("test mode %h done", c);
  endtask
  task automatic test_done();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************
  // Clock, watchdog and test sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #300000;
    mismatches++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    cal = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wd = 16'h0000;
    conv = {8'hA5, 8'h5A, 8'hC3, 8'h3C, 1'b1};
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(ocs_pkg::REG_CTRL, 16'h0002, "ctrl");
    rchk(ocs_pkg::REG_PHASE, 16'h0000, "phase");
    rchk(4'h2, 16'h0000, "unmapped");
    reg_wr(ocs_pkg::REG_PHASE, 16'h0380);
    rchk(ocs_pkg::REG_DELAY, 16'h004D, "delay");
    reg_wr(ocs_pkg::REG_PHASE, 16'h7F80);
    reg_wr(ocs_pkg::REG_DELAY, 16'hFFFF);
    rchk(ocs_pkg::REG_DELAY, 16'h082C, "delay max");
    rchk(ocs_pkg::REG_PHASE, 16'h7F80, "phase back");
    repeat (40) @(posedge clk);
    #1 chk("conv word", 33'(conv), 33'(word));
    $display("test registers done");
    run_mode(16'h0003, 10'h00A, 5, lat0);
    run_mode(16'h000B, 10'h00A, 5, n);
    run_mode(16'h0007, 10'h00A, 5, lat1);
    chk("extra wait", 33'h8, 33'(lat1 - lat0));
    run_mode(16'h0001, 10'h132, 10, n);
    cal <= 1'b1;
    repeat (6) @(posedge clk);
    count_chg(n);
    chk("stopped clock", 33'h0, 33'(n));
    reg_wr(ocs_pkg::REG_CTRL, 16'h0011);
    count_chg(n);
    chk("running clock", 33'h1, 33'(n > 0));
    cal <= 1'b0;
    $display("test calibration done");
    test_done();
  end
endmodule
